//--- design/dual_dac_loader_defines.vh
// Constants of the dual converter serial loader.
`ifndef DUAL_DAC_LOADER_DEFINES_VH
`define DUAL_DAC_LOADER_DEFINES_VH
`define FRAME_BITS 16
`define CODE_BITS 12
`define CTRL_MSB 15
`define CTRL_LSB 12
`define POWER_DOWN_POS 13
`define LATCH_RESET 12'h000
`define CTRL_RESET 4'h0
`define SPEED_POS 14
`define TGT_A 2'h0
`define TGT_B 2'h1
`define TGT_BUF 2'h2
`define TGT_CTRL 2'h3
`define DECODE_TABLE 32'h00000000
`define SCLK_MAX_MHZ 20
`define SYS_CLK_MHZ 100
`endif

//--- design/frame_fifo.v
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module frame_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // Storage carries no reset; out_data shows mem[rd_ptr] even when empty, while out_valid is low.
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

//--- design/dual_dac_serial_loader.v
// Serial frame loader of a dual 12-bit converter with its target latches.
`timescale 1ns/1ps
`include "dual_dac_loader_defines.vh"

// Summary of operation
// - Select fall starts MSB-first shift on falling clock.
// - Full word or select rise moves to latch.
// - Reset clears channel, buffer and control latches.
// - Latches update on rising edge after bit 16.
// - Power-down bit set enters power-down mode.
// - Channel A write updates both outputs together.
// - Converter value is 12-bit unsigned binary.
// - Frame is control bits then 12-bit value.
// - Data ignored while select is high.
module dual_dac_serial_loader #(
  parameter FRAME_BITS = `FRAME_BITS,
  parameter CODE_BITS = `CODE_BITS,
  parameter FIFO_DEPTH = 8,
  parameter [31:0] DECODE_TABLE = `DECODE_TABLE
) (
  input wire sys_clk,
  input wire rst_b,
  input wire sel_b,
  input wire shift_clk,
  input wire ser_data,
  output reg [CODE_BITS-1:0] out_code_a,
  output reg [CODE_BITS-1:0] out_code_b,
  output reg [CODE_BITS-1:0] hold_code,
  output reg [3:0] ctrl_latch,
  output reg power_down,
  output reg fast_mode,
  output wire frame_stall
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  reg [1:0] sel_sync;
  reg [1:0] clk_sync;
  reg [1:0] dat_sync;
  reg sel_q;
  reg clk_q;
  wire sel_n;
  wire clk_n;
  wire dat_n;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // The shift clock idles high, so its edge detector starts high as well.
      // Otherwise a false rising edge would follow every reset.
      sel_sync <= 2'h3;
      clk_sync <= 2'h3;
      dat_sync <= 2'h0;
      sel_q <= 1'b1;
      clk_q <= 1'b1;
    end else begin
      sel_sync <= {sel_sync[0], sel_b};
      clk_sync <= {clk_sync[0], shift_clk};
      dat_sync <= {dat_sync[0], ser_data};
      sel_q <= sel_sync[1];
      clk_q <= clk_sync[1];
    end
  end

  assign sel_n = sel_sync[1];
  assign clk_n = clk_sync[1];
  assign dat_n = dat_sync[1];

  wire sel_fall = sel_q && !sel_n;
  wire sel_rise = !sel_q && sel_n;
  wire clk_fall = clk_q && !clk_n;
  wire clk_rise = !clk_q && clk_n;

  //////////////////////////////////////////////////////////////////////////////
  // Shift register and frame counter.
  reg [FRAME_BITS-1:0] shreg;
  reg [4:0] bit_cnt;
  reg active;
  reg full_wait;
  wire fifo_in_ready;
  reg push;
  reg [FRAME_BITS-1:0] push_word;

  // The data synchroniser has the same depth as the clock synchroniser, so the
  // bit seen at a detected falling edge is the bit set up before the real edge.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shreg <= {FRAME_BITS{1'b0}};
      bit_cnt <= 5'h0;
      active <= 1'b0;
      full_wait <= 1'b0;
      push <= 1'b0;
      push_word <= {FRAME_BITS{1'b0}};
    end else begin
      push <= 1'b0;
      if (sel_fall) begin
        active <= 1'b1;
        bit_cnt <= 5'h0;
        full_wait <= 1'b0;
        // A cut frame must carry zeros above its bits, not the previous word.
        shreg <= {FRAME_BITS{1'b0}};
      end else if (active && sel_n) begin
        active <= 1'b0;
        if (!full_wait && bit_cnt != 5'h0) begin
          push <= 1'b1;
          push_word <= shreg;
        end
      end else if (active && !sel_n) begin
        if (clk_fall && bit_cnt < FRAME_BITS[4:0]) begin
          shreg <= {shreg[FRAME_BITS-2:0], dat_n};
          bit_cnt <= bit_cnt + 5'h1;
        end
        if (clk_rise && bit_cnt == FRAME_BITS[4:0] && !full_wait) begin
          full_wait <= 1'b1;
          push <= 1'b1;
          push_word <= shreg;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame buffer between the serial side and the latch update.
  wire fifo_valid;
  wire [FRAME_BITS-1:0] fifo_word;

  // A full buffer drops the frame; frame_stall flags it to the system.
  assign frame_stall = !fifo_in_ready;

  frame_fifo #(
    .WIDTH(FRAME_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_valid),
    .out_ready(1'b1),
    .out_data(fifo_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Frame decode and target latches.
  wire [3:0] ctrl_bits = fifo_word[`CTRL_MSB:`CTRL_LSB];
  wire [1:0] target = DECODE_TABLE[{ctrl_bits, 1'b0} +: 2];
  wire [CODE_BITS-1:0] code = fifo_word[CODE_BITS-1:0];

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_code_a <= `LATCH_RESET;
      out_code_b <= `LATCH_RESET;
      hold_code <= `LATCH_RESET;
      ctrl_latch <= `CTRL_RESET;
      power_down <= 1'b0;
      fast_mode <= 1'b0;
    end else if (fifo_valid) begin
      if (fifo_word[`POWER_DOWN_POS]) begin
        power_down <= 1'b1;
      end else begin
        power_down <= 1'b0;
        case (target)
          `TGT_A: begin
            out_code_a <= code;
            out_code_b <= hold_code;
          end
          `TGT_B: begin
            out_code_b <= code;
          end
          `TGT_BUF: begin
            hold_code <= code;
          end
          `TGT_CTRL: begin
            ctrl_latch <= ctrl_bits;
            fast_mode <= fifo_word[`SPEED_POS];
          end
          default: begin
            hold_code <= hold_code;
          end
        endcase
      end
    end
  end
endmodule

//--- sim/loader_checker_assertions.sv
// Concurrent checks on the serial loader's latch outputs and frame_stall.
`timescale 1ns/1ps
module loader_checker #(parameter CODE_BITS = 12) (
  input wire sys_clk,
  input wire rst_b,
  input wire sel_b,
  input wire shift_clk,
  input wire [CODE_BITS-1:0] out_code_a,
  input wire [CODE_BITS-1:0] out_code_b,
  input wire [CODE_BITS-1:0] hold_code,
  input wire [3:0] ctrl_latch,
  input wire power_down,
  input wire fast_mode,
  input wire frame_stall
);
  wire [3*CODE_BITS+5:0] outs = {out_code_a, out_code_b, hold_code, ctrl_latch,
    power_down, fast_mode};
  ////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  reset_zero_a: assert property ($rose(rst_b) |-> ~|outs)
    else $error("latches not clear");
  // Latches move only after a rising shift clock, never deep in a low phase.
  clock_low_a: assert property (!shift_clk [*3] |-> $stable(outs))
    else $error("update while clock low");
  idle_hold_a: assert property (sel_b [*8] ##1 sel_b [*8] |-> $stable(outs))
    else $error("update while deselected");
  both_out_a: assert property ($changed(out_code_a) |-> out_code_b == $past(hold_code))
    else $error("outputs not updated together");
  pd_keep_a: assert property ($rose(power_down) |-> $stable({outs[3*CODE_BITS+5:2]}))
    else $error("power down frame wrote a latch");
  one_target_a: assert property ($changed(hold_code) |-> $stable(out_code_a))
    else $error("two targets in one frame");
  fast_bit_a: assert property (fast_mode == ctrl_latch[2])
    else $error("speed bit differs from control");
  no_stall_a: assert property (!frame_stall)
    else $error("frame dropped");
endmodule
bind dual_dac_serial_loader loader_checker #(.CODE_BITS(CODE_BITS)) u_chk (.*);

//--- sim/host_serial_model.sv
// Host serial port model driving select, shift clock and data.
`timescale 1ns/1ps
module host_serial_model (
  input wire sys_clk,
  output logic sel_b = 1'b1,
  output logic shift_clk = 1'b1,
  output logic ser_data = 1'b0
);
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // With hi set the select stays high, so the loader must ignore the bits.
  task automatic send(input logic [15:0] w, input int n, input int gap, input logic hi);
    tick(3);
    sel_b = hi;
    tick(3);
    for (int i = n - 1; i >= 0; i--) begin
      ser_data = w[i];
      if (i == 7) tick(gap);
      tick(4);
      shift_clk = 1'b0;
      tick(8);
      shift_clk = 1'b1;
      tick(4);
    end
    sel_b = 1'b1;
    ser_data = ~ser_data;
    tick(16);
  endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the dual converter serial loader.
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] MAP = 32'h03030204;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  wire sel_b, shift_clk, ser_data, power_down, fast_mode, frame_stall;
  wire [11:0] out_code_a, out_code_b, hold_code;
  wire [3:0] ctrl_latch;
  wire [41:0] seen = {out_code_a, out_code_b, hold_code, ctrl_latch, power_down, fast_mode};
  logic [41:0] st = 42'h0;
  logic [3:0] kinds [6] = '{4'h0, 4'h1, 4'h4, 4'h8, 4'hc, 4'h2};
  int num_errors = 0, n_compared = 0, cycles = 0;
  dual_dac_serial_loader #(.DECODE_TABLE(MAP)) uut (.*);
  host_serial_model u_host (.*);
  function automatic logic [41:0] nxt(input logic [41:0] s, input logic [15:0] f);
    logic [1:0] t;
    t = MAP[2 * f[15:12] +: 2];
    nxt = {s[41:2], 1'b0, s[0]};
    if (f[13]) nxt[1] = 1'b1;
    else if (t == 2'h0) nxt[41:18] = {f[11:0], s[17:6]};
    else if (t == 2'h1) nxt[29:18] = f[11:0];
    else if (t == 2'h2) nxt[17:6] = f[11:0];
    else nxt[5:0] = {f[15:12], 1'b0, f[14]};
  endfunction
  task automatic chk(input logic [41:0] got, input logic [41:0] want);
    n_compared++;
    if (got !== want) begin
      num_errors++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic frame(input logic [15:0] f, input int n, input int gap, input logic hi);
    u_host.send(f, n, gap, hi);
    if (!hi) st = nxt(st, f);
    chk(seen, st);
  endtask
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'hae0bec8a));
    repeat (8) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    u_host.tick(3);
    chk(seen, st);
    for (int k = 0; k < 12; k++) frame({kinds[k % 6], {12{k < 6}}}, 16, 0, 1'b0);
    for (int k = 0; k < 20; k++)
      frame({kinds[$urandom % 6], 12'($urandom)}, 16, k % 2 * 24, 1'b0);
    frame(16'h0a5c, 12, 0, 1'b0);
    frame(16'h0005, 3, 0, 1'b0);
    frame(16'hffff, 16, 0, 1'b1);
    rst_b = 1'b0;
    u_host.tick(2);
    rst_b = 1'b1;
    st = 42'h0;
    u_host.tick(3);
    chk(seen, st);
    frame(16'h1abc, 16, 0, 1'b0);
    report_and_stop();
  end
endmodule
